// file: common/slc_defines.svh
// register addresses, field positions, widths and reset values of the sweep/list config bank
`ifndef SLC_DEFINES_SVH
`define SLC_DEFINES_SVH
`define SLC_ADDR_REINIT   8'h01
`define SLC_ADDR_LED      8'h02
`define SLC_ADDR_SYNTH    8'h03
`define SLC_ADDR_MODE     8'h04
`define SLC_ADDR_SWEEP    8'h05
`define SLC_REINIT_FULL_BIT 0
`define SLC_LED_BIT       0
`define SLC_LOCK_BIT      0
`define SLC_GAIN_BIT      1
`define SLC_SPURDIS_BIT   2
`define SLC_MODE_BIT      0
`define SLC_SRC_BIT       0
`define SLC_DIR_BIT       1
`define SLC_TRI_BIT       2
`define SLC_HWTRIG_BIT    3
`define SLC_STEPTRIG_BIT  4
`define SLC_SYNTH_W       3
`define SLC_SWEEP_W       5
`define SLC_FREQ_W        48
`define SLC_SYNTH_RST     3'h0
`define SLC_SWEEP_RST     5'h00
`define SLC_FREQ_RST      48'h0
`define SLC_BIT_RST       1'h0
`define SLC_TRIG_IDLE     1'h1
`endif

// file: common/slc_pkg.sv
// types shared by the sweep/list config bank
package slc_pkg;
   typedef enum logic {SLC_IDLE, SLC_RUN} slc_state_e;
endpackage : slc_pkg

// file: rtl/slc_regs.sv
// sweep/list configuration registers with trigger handling and point sequencing
// Function
// - reinit write: bit0 selects keep or power-up
// - activity register bit0 drives indicator lamp
// - synth bit0 selects harmonic or fractional lock
// - synth bit1 selects normal or low gain
// - synth bit2 disables automatic fractional switch
// - fixed tone mode accepts frequency changes
// - sweep mode ignores fixed frequency writes
// - source bit0 low takes list buffer
// - source bit0 high computes start/stop/step points
// - forward direction begins at start, steps up
// - reverse direction begins at stop, steps down
// - sawtooth jumps back at cycle end
// - software trigger only starts or stops
// - hardware trigger is external falling edge
// - hardware trigger starts/stops or steps
// - step per trigger needs hardware source
`include "slc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module slc_regs
   import slc_pkg::*;
(
   input  wire logic                   mclk_i,        // 200 MHz clock
   input  wire logic                   rst_n_i,       // async reset, low
   input  wire logic                   wr_en_i,       // register write strobe
   input  wire logic [7:0]             wr_addr_i,     // register address
   input  wire logic [7:0]             wr_data_i,     // register data byte
   input  wire logic                   freq_wr_i,     // fixed tone word write
   input  wire logic [`SLC_FREQ_W-1:0] freq_data_i,   // fixed tone word
   input  wire logic                   soft_trig_i,   // software trigger pulse
   input  wire logic                   ext_trig_i,    // external trigger pin
   input  wire logic                   dwell_done_i,  // dwell time elapsed
   input  wire logic                   end_reached_i, // at last point of pass
   input  wire logic                   begin_reached_i, // at first point
   input  wire logic                   spur_risk_i,   // intermod spur predicted
   output logic                        reinit_o,      // reinit pulse
   output logic                        reinit_full_o, // power-up reinit pulse
   output logic                        led_on_o,      // access lamp
   output logic [`SLC_SYNTH_W-1:0]     synth_cfg_o,   // synth lock config
   output logic                        fractional_divider_active_o, // fractional lock in use
   output logic                        sweep_mode_o,  // sweep/list operation
   output logic [`SLC_SWEEP_W-1:0]     sweep_cfg_o,   // sweep behaviour config
   output logic [`SLC_FREQ_W-1:0]      fixed_tone_frequency_o, // fixed tone word
   output logic                        run_o,         // sequence running
   output logic                        restart_o,     // load beginning point
   output logic                        step_o,        // advance one point
   output logic                        step_down_o,   // current step direction
   output logic                        cycle_done_o   // one cycle finished
);
   // write decode
   wire wr_reinit = wr_en_i && (wr_addr_i == `SLC_ADDR_REINIT);
   wire wr_led    = wr_en_i && (wr_addr_i == `SLC_ADDR_LED);
   wire wr_synth  = wr_en_i && (wr_addr_i == `SLC_ADDR_SYNTH);
   wire wr_mode   = wr_en_i && (wr_addr_i == `SLC_ADDR_MODE);
   wire wr_sweep  = wr_en_i && (wr_addr_i == `SLC_ADDR_SWEEP);
   wire full_clr  = wr_reinit && wr_data_i[`SLC_REINIT_FULL_BIT];

   // field decode of the stored configuration
   wire lock_fractional_divider  = synth_cfg_o[`SLC_LOCK_BIT];
   wire spur_dis    = synth_cfg_o[`SLC_SPURDIS_BIT];
   wire dir_rev     = sweep_cfg_o[`SLC_DIR_BIT];
   wire triangle    = sweep_cfg_o[`SLC_TRI_BIT];
   wire hw_sel      = sweep_cfg_o[`SLC_HWTRIG_BIT];
   wire step_on_trg = sweep_cfg_o[`SLC_STEPTRIG_BIT] && hw_sel;

   // pulses, cleared back after one cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reinit_o      <= `SLC_BIT_RST;
         reinit_full_o <= `SLC_BIT_RST;
      end else begin
         reinit_o      <= wr_reinit;
         reinit_full_o <= full_clr;
      end
   end

   // access lamp
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         led_on_o <= `SLC_BIT_RST;
      else if (full_clr)
         led_on_o <= `SLC_BIT_RST;
      else if (wr_led)
         led_on_o <= wr_data_i[`SLC_LED_BIT];
   end

   // synthesiser config, upper bits dropped
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         synth_cfg_o <= `SLC_SYNTH_RST;
      else if (full_clr)
         synth_cfg_o <= `SLC_SYNTH_RST;
      else if (wr_synth)
         synth_cfg_o <= wr_data_i[`SLC_SYNTH_W-1:0];
   end

   // effective lock method, auto switch only from harmonic mode
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         fractional_divider_active_o <= `SLC_BIT_RST;
      else
         fractional_divider_active_o <= lock_fractional_divider || (!spur_dis && spur_risk_i);
   end

   // output mode
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         sweep_mode_o <= `SLC_BIT_RST;
      else if (full_clr)
         sweep_mode_o <= `SLC_BIT_RST;
      else if (wr_mode)
         sweep_mode_o <= wr_data_i[`SLC_MODE_BIT];
   end

   // sweep behaviour config
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         sweep_cfg_o <= `SLC_SWEEP_RST;
      else if (full_clr)
         sweep_cfg_o <= `SLC_SWEEP_RST;
      else if (wr_sweep)
         sweep_cfg_o <= wr_data_i[`SLC_SWEEP_W-1:0];
   end

   // fixed tone word, frozen while sweeping
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         fixed_tone_frequency_o <= `SLC_FREQ_RST;
      else if (full_clr)
         fixed_tone_frequency_o <= `SLC_FREQ_RST;
      else if (freq_wr_i && !sweep_mode_o)
         fixed_tone_frequency_o <= freq_data_i;
   end

   // external trigger edge detect, pin idles high
   logic trig_d_r;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         trig_d_r <= `SLC_TRIG_IDLE;
      else
         trig_d_r <= ext_trig_i;
   end

   // trigger qualification; nothing acts outside sweep mode
   wire hw_fall   = trig_d_r && !ext_trig_i;
   wire trig_ok   = sweep_mode_o;
   wire ss_trig   = trig_ok && ((!hw_sel && soft_trig_i) ||
                                (hw_fall && hw_sel && !step_on_trg));
   wire step_trig = trig_ok && hw_fall && step_on_trg;
   wire sw_stop   = trig_ok && soft_trig_i;              // soft trigger always stops

   // sequencer state
   slc_state_e state_r;
   slc_state_e state_nxt;
   logic       back_r;                                   // on triangle return leg
   logic       back_nxt;
   logic       restart_nxt;
   logic       step_nxt;
   logic       done_nxt;

   // advance source: dwell timer, or trigger in step mode
   wire advance  = step_on_trg ? step_trig : dwell_done_i;
   wire at_end   = !back_r && end_reached_i;
   wire at_home  = back_r && begin_reached_i;
   wire stop_now = ss_trig || sw_stop || !sweep_mode_o;

   // next-state logic
   always_comb begin
      state_nxt   = state_r;
      back_nxt    = back_r;
      restart_nxt = 1'b0;
      step_nxt    = 1'b0;
      done_nxt    = 1'b0;
      case (state_r)
         SLC_IDLE: begin
            if (ss_trig || step_trig) begin
               state_nxt   = SLC_RUN;
               back_nxt    = 1'b0;
               restart_nxt = 1'b1;
            end
         end
         SLC_RUN: begin
            if (stop_now) begin
               state_nxt = SLC_IDLE;
            end else if (advance && at_end && !triangle) begin
               restart_nxt = 1'b1;
               done_nxt    = 1'b1;
            end else if (advance && at_end) begin
               back_nxt = 1'b1;
               step_nxt = 1'b1;
            end else if (advance && at_home) begin
               back_nxt = 1'b0;
               step_nxt = 1'b1;
               done_nxt = 1'b1;
            end else if (advance) begin
               step_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = SLC_IDLE;
            back_nxt  = 1'b0;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= SLC_IDLE;
         back_r  <= `SLC_BIT_RST;
      end else begin
         state_r <= state_nxt;
         back_r  <= back_nxt;
      end
   end

   // sequencer outputs, registered
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_o        <= `SLC_BIT_RST;
         restart_o    <= `SLC_BIT_RST;
         step_o       <= `SLC_BIT_RST;
         step_down_o  <= `SLC_BIT_RST;
         cycle_done_o <= `SLC_BIT_RST;
      end else begin
         run_o        <= (state_nxt == SLC_RUN);
         restart_o    <= restart_nxt;
         step_o       <= step_nxt;
         step_down_o  <= dir_rev ^ back_nxt;
         cycle_done_o <= done_nxt;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // register store checks
   led_follow_a: assert property (wr_led |=>
                                  led_on_o == $past(wr_data_i[`SLC_LED_BIT]))
      else $error("lamp did not follow write");
   lock_sel_a: assert property (wr_synth |=>
                                synth_cfg_o == $past(wr_data_i[`SLC_SYNTH_W-1:0]))
      else $error("synth config not taken");
   gain_sel_a: assert property (wr_synth |=>
                                synth_cfg_o[`SLC_GAIN_BIT] == $past(wr_data_i[`SLC_GAIN_BIT]))
      else $error("loop gain bit not taken");
   auto_fractional_divider_a: assert property (!lock_fractional_divider && !spur_dis && spur_risk_i
                                  |=> fractional_divider_active_o)
      else $error("no automatic fractional switch");
   freq_block_a: assert property (freq_wr_i && sweep_mode_o && !full_clr
                                  |=> $stable(fixed_tone_frequency_o))
      else $error("fixed word changed in sweep mode");
   freq_take_a: assert property (freq_wr_i && !sweep_mode_o && !full_clr
                                 |=> fixed_tone_frequency_o == $past(freq_data_i))
      else $error("fixed word not taken");
   mode_take_a: assert property (wr_mode |=>
                                 sweep_mode_o == $past(wr_data_i[`SLC_MODE_BIT]))
      else $error("output mode not taken");
   cfg_take_a: assert property (wr_sweep |=>
                                sweep_cfg_o == $past(wr_data_i[`SLC_SWEEP_W-1:0]))
      else $error("sweep config not taken");
   full_reinit_a: assert property (full_clr |=> !sweep_mode_o && reinit_full_o
                                   && sweep_cfg_o == `SLC_SWEEP_RST
                                   && synth_cfg_o == `SLC_SYNTH_RST && !led_on_o
                                   && fixed_tone_frequency_o == `SLC_FREQ_RST)
      else $error("power-up reinit incomplete");
   keep_reinit_a: assert property (wr_reinit && !full_clr |=> reinit_o
                                   && !reinit_full_o)
      else $error("keep-settings reinit wrong");

   // trigger and sequencer checks
   fixed_idle_a: assert property (!sweep_mode_o |=> !run_o)
      else $error("running outside sweep mode");
   soft_start_a: assert property (state_r == SLC_IDLE && sweep_mode_o
                                  && !hw_sel && soft_trig_i |=> run_o && restart_o)
      else $error("soft trigger did not start");
   hw_ignore_a: assert property (state_r == SLC_IDLE && !hw_sel && !soft_trig_i
                                 |=> !run_o)
      else $error("pin edge acted while not selected");
   soft_nostep_a: assert property (state_r == SLC_RUN && !step_on_trg
                                   && !dwell_done_i |=> !step_o && !restart_o)
      else $error("step without dwell");
   hw_step_a: assert property (state_r == SLC_RUN && step_trig && !stop_now
                               && !at_end |=> step_o)
      else $error("hardware trigger did not step");
   saw_jump_a: assert property (state_r == SLC_RUN && !stop_now && advance && at_end
                                && !triangle |=> restart_o && cycle_done_o)
      else $error("sawtooth did not jump back");
   tri_turn_a: assert property (state_r == SLC_RUN && !stop_now && advance && at_end
                                && triangle |=> step_o && step_down_o != dir_rev)
      else $error("triangle did not reverse");
   begin_dir_a: assert property (restart_o |-> step_down_o == dir_rev)
      else $error("wrong beginning direction");

   // triangle turn followed by the end of its cycle
   sequence tri_turn_a_seq;
      step_o && back_r ##[1:20] cycle_done_o;
   endsequence

   // scenario covers
   start_c:   cover property (state_r == SLC_IDLE ##1 restart_o);
   turn_c:    cover property (tri_turn_a_seq);
   hwstep_c:  cover property (step_trig && state_r == SLC_RUN);
   reinit_c:  cover property (full_clr);
   sawjump_c: cover property (restart_o && cycle_done_o);
endmodule : slc_regs
`default_nettype wire

// file: testbench/slc_host_model.sv
// host model that writes the config bytes and raises triggers
`timescale 1ns/1ps
`default_nettype none
module slc_host_model (
   input  wire logic        mclk_i,  // bench clock
   output logic             we_o,    // write strobe
   output logic [7:0]       wa_o,    // register address
   output logic [7:0]       wd_o,    // register data byte
   output logic             fw_o,    // tone word strobe
   output logic [47:0]      fd_o,    // tone word
   output logic             st_o,    // software trigger
   output logic             xt_o     // external trigger pin
);
   // idle levels, the trigger pin idles high
   initial begin
      we_o = 1'b0;
      wa_o = 8'h00;
      wd_o = 8'h00;
      fw_o = 1'b0;
      fd_o = 48'h0;
      st_o = 1'b0;
      xt_o = 1'b1;
   end
   // byte write; released lines show the inverse so nothing stale looks held
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      we_o = 1'b1;
      wa_o = a;
      wd_o = d;
      @(negedge mclk_i);
      we_o = 1'b0;
      wa_o = ~a;
      wd_o = ~d;
   endtask : wr
   // tone word write
   task automatic fw(input logic [47:0] d);
      @(negedge mclk_i);
      fw_o = 1'b1;
      fd_o = d;
      @(negedge mclk_i);
      fw_o = 1'b0;
      fd_o = ~d;
   endtask : fw
   // sweep mode is set before any trigger is sent
   task automatic arm();
      wr(8'h04, 8'h01);
   endtask : arm
   // one-cycle soft pulse, or a falling edge on the pin
   task automatic trig(input logic hw);
      @(negedge mclk_i);
      if (hw) xt_o = 1'b0;
      else st_o = 1'b1;
      @(negedge mclk_i);
      xt_o = 1'b1;
      st_o = 1'b0;
   endtask : trig
   // one cycle of random strobes and triggers on an undecoded address
   task automatic poke(input logic [3:0] r, input logic [7:0] a, input logic [47:0] d);
      @(negedge mclk_i);
      we_o = r[0];
      wa_o = a;
      wd_o = d[7:0];
      fw_o = r[1];
      fd_o = d;
      st_o = r[2];
      xt_o = r[3];
      @(negedge mclk_i);
      we_o = 1'b0;
      wa_o = ~a;
      wd_o = ~d[7:0];
      fw_o = 1'b0;
      fd_o = ~d;
      st_o = 1'b0;
      xt_o = 1'b1;
   endtask : poke
endmodule : slc_host_model
`default_nettype wire

// file: testbench/slc_regs_tb.sv
// self-checking bench for the sweep/list config bank
`timescale 1ns/1ps
`default_nettype none
module slc_regs_tb;
   localparam logic [3:0] ALL=0, LED=1, SYN=2, FRC=3, CFG=4, RUN=5, RS=6, STP=7, SDN=8,
      CYC=9, REI=10, RF=11, MOD=12, FRQ=13;
   logic        mclk_i, rst_n_i, dwell, at_end, at_beg, spur;
   logic        we, fw, st, xt, rei, reif, led, frac, mode, run, rs, stp, sdn, cyc;
   logic [7:0]  wa, wd;
   logic [47:0] fd, freq, v, fx;
   logic [2:0]  syn;
   logic [4:0]  cfg;
   logic [51:0] note, notes[$];
   int          fail_count, total_checks, i;
   // 200 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   slc_host_model i_slc_host_model (.mclk_i(mclk_i), .we_o(we), .wa_o(wa), .wd_o(wd),
      .fw_o(fw), .fd_o(fd), .st_o(st), .xt_o(xt));
   slc_regs i_slc_regs (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_en_i(we), .wr_addr_i(wa),
      .wr_data_i(wd), .freq_wr_i(fw), .freq_data_i(fd), .soft_trig_i(st), .ext_trig_i(xt),
      .dwell_done_i(dwell), .end_reached_i(at_end), .begin_reached_i(at_beg),
      .spur_risk_i(spur), .reinit_o(rei), .reinit_full_o(reif), .led_on_o(led),
      .synth_cfg_o(syn), .fractional_divider_active_o(frac), .sweep_mode_o(mode), .sweep_cfg_o(cfg),
      .fixed_tone_frequency_o(freq), .run_o(run), .restart_o(rs), .step_o(stp),
      .step_down_o(sdn), .cycle_done_o(cyc));
   // output picked by a note's selector
   function automatic logic [47:0] seen(input logic [3:0] k);
      case (k)
         ALL: seen = {30'h0, rei, reif, led, syn, frac, mode, cfg, run, rs, stp, sdn, cyc};
         LED: seen = 48'(led);
         SYN: seen = 48'(syn);
         FRC: seen = 48'(frac);
         CFG: seen = 48'(cfg);
         RUN: seen = 48'(run);
         RS: seen = 48'(rs);
         STP: seen = 48'(stp);
         SDN: seen = 48'(sdn);
         CYC: seen = 48'(cyc);
         REI: seen = 48'(rei);
         RF: seen = 48'(reif);
         MOD: seen = 48'(mode);
         default: seen = freq;
      endcase
   endfunction : seen
   // records an expected value for the watcher
   task automatic chk(input logic [3:0] k, input logic [47:0] e);
      notes.push_back({k, e});
   endtask : chk
   // compares one value and counts
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: output %0h, expected %0h", $time, got, exp);
      end
   endtask : check
   // counts, verdict and end of run
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   // one dwell pulse with the position levels
   task automatic dw(input logic e, input logic b);
      @(negedge mclk_i);
      dwell = 1'b1;
      at_end = e;
      at_beg = b;
      @(negedge mclk_i);
      dwell = 1'b0;
      at_end = 1'b0;
      at_beg = 1'b0;
   endtask : dw
   // oldest notes against what the last edge produced
   always @(posedge mclk_i) begin
      while (notes.size() > 0) begin
         note = notes.pop_front();
         check(seen(note[51:48]), note[47:0]);
      end
   end
   // bound on the whole run
   initial begin
      for (int n = 0; n < 20000; n++) @(posedge mclk_i);
      fail_count++;
      print_verdict();
   end
   // main sequence
   initial begin
      v = 48'($urandom(29));
      rst_n_i = 1'b0;
      dwell = 1'b0;
      at_end = 1'b0;
      at_beg = 1'b0;
      spur = 1'b0;
      fail_count = 0;
      total_checks = 0;
      repeat (20) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_n_i = 1'b1;
      chk(ALL, 48'h0);
      chk(FRQ, 48'h0);
      i_slc_host_model.wr(8'h02, 8'h01);
      chk(LED, 48'h1);
      i_slc_host_model.wr(8'h06, 8'h00);
      chk(ALL, 48'h8000);
      i_slc_host_model.wr(8'h02, 8'hFE);
      chk(LED, 48'h0);
      $display("lamp test done");
      for (i = 0; i < 8; i++) begin
         v = 48'($urandom);
         spur = v[8];
         i_slc_host_model.wr(8'h03, v[7:0]);
         chk(SYN, 48'(v[2:0]));
         @(negedge mclk_i);
         chk(FRC, 48'(v[0] | (~v[2] & spur)));
      end
      $display("synth test done");
      spur = 1'b0;
      i_slc_host_model.wr(8'h02, 8'h01);
      i_slc_host_model.wr(8'h01, 8'h00);
      chk(REI, 48'h1);
      chk(RF, 48'h0);
      chk(LED, 48'h1);
      i_slc_host_model.wr(8'h01, 8'hFF);
      chk(RF, 48'h1);
      repeat (2) @(negedge mclk_i);
      chk(ALL, 48'h0);
      $display("reinit test done");
      v = 48'({$urandom, $urandom});
      i_slc_host_model.fw(v);
      chk(FRQ, v);
      i_slc_host_model.arm();
      chk(MOD, 48'h1);
      i_slc_host_model.fw(~v);
      chk(FRQ, v);
      for (i = 0; i < 32; i++) begin
         i_slc_host_model.wr(8'h05, {v[2:0], 5'(i)});
         chk(CFG, 48'(i));
      end
      $display("store test done");
      i_slc_host_model.wr(8'h05, 8'h00);
      i_slc_host_model.trig(1'b0);
      chk(RUN, 48'h1);
      chk(RS, 48'h1);
      dw(1'b1, 1'b0);
      chk(RS, 48'h1);
      chk(CYC, 48'h1);
      i_slc_host_model.trig(1'b0);
      chk(RUN, 48'h0);
      i_slc_host_model.wr(8'h05, 8'h10);
      i_slc_host_model.trig(1'b0);
      dw(1'b0, 1'b0);
      chk(STP, 48'h1);
      chk(SDN, 48'h0);
      i_slc_host_model.trig(1'b1);
      chk(RUN, 48'h1);
      chk(STP, 48'h0);
      i_slc_host_model.trig(1'b0);
      $display("soft trigger test done");
      i_slc_host_model.wr(8'h05, 8'h1A);
      i_slc_host_model.trig(1'b1);
      chk(RS, 48'h1);
      dw(1'b0, 1'b0);
      chk(STP, 48'h0);
      i_slc_host_model.trig(1'b1);
      chk(STP, 48'h1);
      chk(SDN, 48'h1);
      i_slc_host_model.trig(1'b0);
      chk(RUN, 48'h0);
      i_slc_host_model.wr(8'h05, 8'h0C);
      i_slc_host_model.trig(1'b1);
      chk(RUN, 48'h1);
      dw(1'b1, 1'b0);
      chk(STP, 48'h1);
      chk(SDN, 48'h1);
      dw(1'b0, 1'b1);
      chk(CYC, 48'h1);
      chk(SDN, 48'h0);
      i_slc_host_model.trig(1'b1);
      chk(RUN, 48'h0);
      $display("hardware trigger test done");
      i_slc_host_model.trig(1'b1);
      i_slc_host_model.wr(8'h04, 8'h00);
      @(negedge mclk_i);
      chk(RUN, 48'h0);
      i_slc_host_model.trig(1'b1);
      chk(RUN, 48'h0);
      @(negedge mclk_i);
      $display("mode test done");
      fx = v;
      for (i = 0; i < 16; i++) begin
         v = 48'({$urandom, $urandom});
         dwell = v[0];
         at_end = v[1];
         at_beg = v[2];
         i_slc_host_model.poke(v[6:3], {1'b1, v[14:8]}, v);
         if (v[4]) fx = v;
         chk(FRQ, fx);
         chk(ALL, 48'h180);
      end
      dwell = 1'b0;
      at_end = 1'b0;
      at_beg = 1'b0;
      @(negedge mclk_i);
      $display("noise test done");
      print_verdict();
   end
endmodule : slc_regs_tb
`default_nettype wire
